// *** logic/sdspi_map.svh ***
// Constants for the stepper driver serial port: widths, fields, timing
`ifndef SDSPI_MAP_SVH
`define SDSPI_MAP_SVH
`define SD_LEN       40
`define SD_DW        32
`define SD_WR_BIT    39
`define SD_ADDR_HI   38
`define SD_ADDR_LO   32
`define SD_ST_HI     39
`define SD_ST_LO     32
`define SD_ST_RSV    5'h00
`define SD_ST_RST    8'h00
`define SD_DATA_RST  32'h0000_0000
`define SD_FLAG_RST  3'h1
`define SD_GLOBAL_STATUS_REGISTER_ADR 7'h01
`define SD_FILT_NS   20
`define SD_CLK_NS    50
`define SD_FILT_CYC  2'((`SD_FILT_NS + `SD_CLK_NS - 1) / `SD_CLK_NS)
`define SD_CNT_MAX   6'h3f
`endif

// *** logic/sdspi_pkg.sv ***
// Types shared by the stepper driver serial port
package sdspi_pkg;
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [31:0] data;
  } sdspi_cmd_t;
  typedef struct packed {
    logic output_disable_n;
    logic csn;
    logic sdi;
    logic sck;
  } sdspi_pins_t;
  typedef enum logic {SDSPI_IDLE, SDSPI_XFER} sdspi_st_t;
endpackage

// *** logic/sdspi_slave.sv ***
// Serial port slave of the dual stepper driver: framing, status, daisy chain
// Overview of operation
// - Bit 39 set means write, clear means read; write address is address plus 0x80.
// - Every frame returns 32 data bits; a read's register comes back next frame.
// - After a write frame, the next frame returns that written data.
// - A read frame carries only the address; its data bits update nothing.
// - Every returned frame carries the 8-bit status byte in bits 39..32.
// - Status is captured at the end of each access, sent in the next.
// - Status bits 7..3 read zero; bit 2, 1 stage faults; bit 0 reset seen.
// - Status flags mirror global status bits 2..0, held until that register is read.
// - Narrow values are right aligned, signed ones two's complement.
// - With select low, sample input on clock rise, drive output after fall, MSB first.
// - Beyond 40 clocks, input bits leave on the output 40 clocks later.
// - On select rise the last 40 bits shifted in become the command.
// - All port inputs and output disable ignore pulses shorter than 20 ns.
// - Mode 3: clock idles high, shift out on fall, sample on rise.
`include "sdspi_map.svh"

module sdspi_slave (
  // Clock, reset, enable
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_ce,
  // Serial port pins
  input  wire logic                 i_sck,
  input  wire logic                 i_sdi,
  input  wire logic                 i_csn,
  output logic                      o_sdo,
  output logic                      o_sdo_oe,
  // Output disable pin and its filtered copy
  input  wire logic                 i_output_disable_n,
  output logic                      o_output_disable_n,
  // Command to the register map
  output logic                      o_cmd_valid,
  output sdspi_pkg::sdspi_cmd_t     o_cmd,
  input  wire logic [31:0]          i_rd_data,
  // Driver events and status
  input  wire logic [2:0]           i_flag_set,
  output logic [2:0]                o_global_status_register,
  output logic [7:0]                o_transfer_status_byte
);
  import sdspi_pkg::*;

  // Raw pins gathered so the filter can be one loop
  sdspi_pins_t pin_raw;
  sdspi_pins_t pin_f;

  assign pin_raw = '{output_disable_n: i_output_disable_n, csn: i_csn,
                     sdi: i_sdi, sck: i_sck};

  // Two-stage synchroniser then a stability filter per pin.
  // A pulse must survive the sync and then hold for the filter
  // count, so anything under one clock never reaches the logic.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      logic       s1_q;
      logic       s2_q;
      logic       f_q;
      logic [1:0] cnt_q;
      wire        diff = s2_q != f_q;
      wire        done = cnt_q == `SD_FILT_CYC;
      // Sync flops and filter, all idle high like the bus pins
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          s1_q  <= 1'b1;
          s2_q  <= 1'b1;
          f_q   <= 1'b1;
          cnt_q <= 2'h0;
        end else if (i_ce) begin
          s1_q  <= pin_raw[gi];
          s2_q  <= s1_q;
          f_q   <= (diff && done) ? s2_q : f_q;
          cnt_q <= (diff && !done) ? cnt_q + 2'h1 : 2'h0;
        end
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  // Edge history of the filtered clock and select
  logic sck_prev_q;
  logic csn_prev_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_prev_q <= 1'b1;
      csn_prev_q <= 1'b1;
    end else if (i_ce) begin
      sck_prev_q <= pin_f.sck;
      csn_prev_q <= pin_f.csn;
    end
  end

  // Edge decode on the filtered, synchronised signals
  wire sck_rise = pin_f.sck & ~sck_prev_q;
  wire sck_fall = ~pin_f.sck & sck_prev_q;
  wire csn_fall = ~pin_f.csn & csn_prev_q;
  wire csn_rise = pin_f.csn & ~csn_prev_q;

  // Frame state, shift register and reply data
  sdspi_st_t   st_q;
  sdspi_st_t   st_d;
  logic [39:0] shift_q;
  logic [39:0] shift_d;
  logic [31:0] out_data_q;
  logic [31:0] out_data_d;
  logic        rd_pend_q;
  logic [7:0]  status_q;
  logic [2:0]  flags_q;
  logic [2:0]  flags_d;
  logic        sdo_q;

  // Fields of the frame just completed
  wire       f_wr   = shift_q[`SD_WR_BIT];
  wire [6:0] f_addr = shift_q[`SD_ADDR_HI:`SD_ADDR_LO];
  wire [31:0] f_data = shift_q[`SD_DW-1:0];
  wire       active = st_q == SDSPI_XFER;
  wire       rd_global_status_register = csn_rise & active & ~f_wr & (f_addr == `SD_GLOBAL_STATUS_REGISTER_ADR);
  wire [7:0] status_now = {`SD_ST_RSV, flags_q};

  // Frame sequencing: select low opens, select high closes
  always_comb begin
    st_d = st_q;
    case (st_q)
      SDSPI_IDLE: begin
        if (csn_fall) begin
          st_d = SDSPI_XFER;
        end
      end
      SDSPI_XFER: begin
        if (csn_rise) begin
          st_d = SDSPI_IDLE;
        end
      end
      default: st_d = SDSPI_IDLE;
    endcase
  end

  // Shift register: load reply at frame start, shift on rising clock.
  // Bits pushed past 40 fall out the top, which is the daisy chain.
  always_comb begin
    shift_d = shift_q;
    if (csn_fall) begin
      shift_d = {status_q, out_data_q};
    end else if (active && sck_rise) begin
      shift_d = {shift_q[`SD_LEN-2:0], pin_f.sdi};
    end
  end

  // Reply data for the next frame: write echo or read snapshot
  always_comb begin
    out_data_d = out_data_q;
    if (o_cmd_valid && o_cmd.wr) begin
      out_data_d = o_cmd.data;
    end else if (rd_pend_q) begin
      out_data_d = i_rd_data;
    end
  end

  // Sticky flags: an event in the clearing cycle wins
  always_comb begin
    flags_d = flags_q;
    if (rd_global_status_register) begin
      flags_d = 3'h0;
    end
    flags_d = flags_d | i_flag_set;
  end

  // Frame registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q       <= SDSPI_IDLE;
      shift_q    <= {`SD_ST_RST, `SD_DATA_RST};
      out_data_q <= `SD_DATA_RST;
    end else if (i_ce) begin
      st_q       <= st_d;
      shift_q    <= shift_d;
      out_data_q <= out_data_d;
    end
  end

  // Status capture at the end of each access
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_q <= `SD_ST_RST;
      flags_q  <= `SD_FLAG_RST;
    end else if (i_ce) begin
      flags_q  <= flags_d;
      if (csn_rise && active) begin
        status_q <= status_now;
      end
    end
  end

  // Command hand-off; read frames carry no data so nothing is written
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cmd_valid <= 1'b0;
      o_cmd       <= '0;
      rd_pend_q   <= 1'b0;
    end else if (i_ce) begin
      o_cmd_valid <= csn_rise & active;
      rd_pend_q   <= csn_rise & active & ~f_wr;
      if (csn_rise && active) begin
        o_cmd.wr   <= f_wr;
        o_cmd.addr <= f_addr;
        o_cmd.data <= f_wr ? f_data : `SD_DATA_RST;
      end
    end
  end

  // Output pin: top bit presented at start and after each falling clock
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sdo_q <= 1'b0;
    end else if (i_ce) begin
      if (csn_fall) begin
        sdo_q <= status_q[7];
      end else if (active && sck_fall) begin
        sdo_q <= shift_q[`SD_LEN-1];
      end
    end
  end

  assign o_sdo = sdo_q;

  // Drive enable, filtered disable pin and mirrored flags
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sdo_oe                 <= 1'b0;
      o_output_disable_n       <= 1'b1;
      o_global_status_register <= `SD_FLAG_RST;
    end else if (i_ce) begin
      o_sdo_oe                 <= st_d == SDSPI_XFER;
      o_output_disable_n       <= pin_f.output_disable_n;
      o_global_status_register <= flags_d;
    end
  end

  assign o_transfer_status_byte = status_q;

  // Rising clock count within a frame, read only by the covers
  logic [5:0] bits_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bits_q <= 6'h00;
    end else if (i_ce) begin
      if (csn_fall) begin
        bits_q <= 6'h00;
      end else if (active && sck_rise && bits_q != `SD_CNT_MAX) begin
        bits_q <= bits_q + 6'h01;
      end
    end
  end

  // Checks on the frame logic
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_WR_DECODE: assert property (
    i_ce && csn_rise && active |=> o_cmd_valid && o_cmd.wr == $past(shift_q[39]))
    else $error("write bit not taken from bit 39");
  AST_RD_SNAP: assert property (
    o_cmd_valid && !o_cmd.wr && i_ce |=> out_data_q == $past(i_rd_data))
    else $error("read data not captured after read");
  AST_WR_ECHO: assert property (
    o_cmd_valid && o_cmd.wr && i_ce |=> out_data_q == $past(o_cmd.data))
    else $error("write data not echoed");
  AST_RD_NODATA: assert property (
    o_cmd_valid && !o_cmd.wr |-> o_cmd.data == 32'h0000_0000)
    else $error("read frame carries data");
  AST_ST_LOAD: assert property (
    i_ce && csn_fall |=> shift_q[39:32] == $past(status_q))
    else $error("status byte not loaded at frame start");
  AST_ST_CAPT: assert property (
    i_ce && csn_rise && active |=> status_q[2:0] == $past(flags_q))
    else $error("status not captured at frame end");
  AST_ST_RSV: assert property (
    status_q[7:3] == 5'h00)
    else $error("reserved status bits set");
  AST_FLAG_HOLD: assert property (
    i_ce && |i_flag_set |=> (flags_q & $past(i_flag_set)) == $past(i_flag_set))
    else $error("flag event lost");
  AST_SDO_FALL: assert property (
    i_ce && active && sck_fall && !csn_fall |=> o_sdo == $past(shift_q[39]))
    else $error("output not updated on falling clock");
  AST_SHIFT_IN: assert property (
    i_ce && active && sck_rise && !csn_fall |=> shift_q[0] == $past(pin_f.sdi))
    else $error("input bit not shifted in");
  AST_CMD_PULSE: assert property (
    o_cmd_valid |=> !o_cmd_valid)
    else $error("command pulse longer than one cycle");

  COV_WRITE: cover property (o_cmd_valid && o_cmd.wr);
  COV_READ_PIPE: cover property (o_cmd_valid && !o_cmd.wr ##[1:1000] o_cmd_valid);
  COV_DAISY: cover property (csn_rise && active && bits_q > 6'(`SD_LEN));
  COV_GLOBAL_STATUS_REGISTER_CLR: cover property (rd_global_status_register && |flags_q);
endmodule

// *** tb/sdspi_master.sv ***
// Serial port master model: mode 3 frames of up to 64 bits
module sdspi_master (
  input  wire logic i_sdo,
  output logic      o_sck,
  output logic      o_sdi,
  output logic      o_csn
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idles with clock high and select high
  initial begin
    o_sck = 1'b1;
    o_sdi = 1'b0;
    o_csn = 1'b1;
  end

  // One frame, MSB first; reply read late in the high phase since sdo lags by sync delay
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = 64'h0;
    #17 o_csn = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      o_sck = 1'b0;
      o_sdi = tx[i];
      #200 o_sck = 1'b1;
      #200 rx = {rx[62:0], i_sdo};
    end
    o_csn = 1'b1;
    o_sdi = ~o_sdi; // Released line shows no stale bit
    #400;
  endtask
endmodule

// *** tb/tb_stepper_driver_spi_slave.sv ***
// Self-checking bench for the stepper driver serial port slave
module tb_stepper_driver_spi_slave;
  import sdspi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       sck, sdi, csn, sdo, sdo_oe, cmd_valid;
  logic       enn_in = 1'b1;
  logic       ce = 1'b1;
  logic       enn_out;
  sdspi_cmd_t cmd, got_cmd;
  logic [31:0] rd_data;
  logic [2:0] flag_set = 3'h0;
  logic [2:0] gsr, m_flags;
  logic [7:0] tsb, m_stat;
  logic [31:0] m_data;
  int         n_errors = 0;
  int         checks_done = 0;
  int         n_cmd = 0;
  int         n_oe = 0;
  int         cyc = 0;
  int         seed = 32'h4f0c73d4;

  // Clock at 20 MHz
  initial begin
    forever #25 clk = ~clk;
  end

  // Register map stand-in: data derived from the address
  function automatic logic [31:0] rd_map(input logic [6:0] a);
    return {4{1'b0, a}} ^ 32'h5a5a_0f0f;
  endfunction
  assign rd_data = rd_map(cmd.addr);

  sdspi_master m (.i_sdo(sdo), .o_sck(sck), .o_sdi(sdi), .o_csn(csn));

  sdspi_slave dut (
    .i_clk(clk), .i_rstn(rstn), .i_ce(ce),
    .i_sck(sck), .i_sdi(sdi), .i_csn(csn), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .i_output_disable_n(enn_in), .o_output_disable_n(enn_out),
    .o_cmd_valid(cmd_valid), .o_cmd(cmd), .i_rd_data(rd_data),
    .i_flag_set(flag_set), .o_global_status_register(gsr), .o_transfer_status_byte(tsb)
  );

  // Record every command pulse; the frame task looks at it afterwards
  always @(posedge clk) begin
    cyc++;
    // Drive enable should stand exactly as long as select is low
    if (sdo_oe === 1'b1) n_oe++;
    if (cmd_valid === 1'b1) begin
      got_cmd <= cmd;
      n_cmd++;
    end
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One frame with ex extra leading bits; reply and command checked against the model
  task automatic frame(input logic [7:0] ab, input logic [31:0] d, input int ex);
    logic [63:0] tx;
    logic [63:0] rx;
    logic [63:0] mk;
    int          k;
    int          oe0;
    k = n_cmd;
    oe0 = n_oe;
    tx = {$random(seed), $random(seed)};
    tx[39:0] = {ab, d};
    mk = (64'h1 << ex) - 64'h1;
    m.xfer(tx, 40 + ex, rx);
    repeat (4) @(posedge clk);
    check((rx >> ex) & 64'hff_ffff_ffff, {m_stat, m_data});
    check(rx & mk, (tx >> 40) & mk);
    check(n_cmd - k, 1);
    check(n_oe - oe0, 4 + 8 * (40 + ex));
    check(got_cmd, {ab, ab[7] ? d : 32'h0});
    m_stat = {5'h00, m_flags};
    if (!ab[7] && ab[6:0] == 7'h01)
      m_flags = 3'h0;
    m_data = ab[7] ? d : rd_map(ab[6:0]);
    check(tsb, m_stat);
    check(gsr, m_flags);
  endtask

  // Driver events: a one-cycle pulse makes a flag sticky
  task automatic pulse(input logic [2:0] f);
    @(posedge clk) flag_set <= f;
    @(posedge clk) flag_set <= 3'h0;
    m_flags = m_flags | f;
    repeat (2) @(posedge clk);
    check(gsr, m_flags);
  endtask

  // Main sequence
  initial begin
    m_flags = 3'h1;
    m_stat = 8'h00;
    m_data = 32'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    check(tsb, 8'h00);
    check(gsr, 3'h1);
    check(sdo_oe, 1'b0);
    frame(8'h21, $random(seed), 0);
    frame(8'h21, 32'h0, 0);
    frame(8'hec, $random(seed), 0);
    frame(8'hec, $random(seed), 8);
    pulse(3'h6);
    frame(8'h81, $random(seed), 0);
    frame(8'h01, $random(seed), 0);
    frame(8'h22, 32'h0, 3);
    for (int i = 0; i < 5; i++) begin
      pulse($random(seed));
      frame($random(seed), $random(seed), {$random(seed)} % 17);
    end
    // Clear the flags, then an event while the enable is low must not land
    frame(8'h01, 32'h0, 0);
    @(posedge clk) ce <= 1'b0;
    flag_set <= 3'h7;
    repeat (3) @(posedge clk);
    check(gsr, m_flags);
    flag_set <= 3'h0;
    ce <= 1'b1;
    // Short glitch across a sampling edge must not pass; a held level must
    @(posedge clk);
    #40 enn_in = 1'b0;
    #15 enn_in = 1'b1;
    repeat (8) @(posedge clk);
    check(enn_out, 1'b1);
    enn_in <= 1'b0;
    repeat (8) @(posedge clk);
    check(enn_out, 1'b0);
    final_report();
  end
endmodule
